/* ctu_defines.vh */
`ifndef CTU_DEFINES_VH
`define CTU_DEFINES_VH

// Source select field width
`define CTU_SEL_W          4
// Range field width and codes
`define CTU_RANGE_W        2
`define CTU_RANGE_X1       2'h1
`define CTU_RANGE_X10      2'h2
`define CTU_RANGE_X100     2'h3
`define CTU_RANGE_X1000    2'h0
// Trim field width and neutral value
`define CTU_TRIM_W         6
`define CTU_TRIM_NEUTRAL   6'h00
// Reset values of control bits
`define CTU_POL_RESET      1'h0
`define CTU_ORDER_RESET    1'h0
`define CTU_TIME_GENERATION_SELECT_RESET     1'h0
`define CTU_TRIG_RESET     1'h0
`define CTU_SEL_RESET      4'h0
// Number of source lines feeding each channel
`define CTU_NSRC           16
// Synchroniser depth for pin sources
`define CTU_SYNC_STAGES    3

`endif

/* edge_channel.v */
`timescale 1ns/1ps
`include "ctu_defines.vh"

// Per-channel source select, synchroniser and polarity qualifier
module edge_channel #(
  parameter NSRC = `CTU_NSRC
) (
  input  wire            clk,
  input  wire            reset,
  input  wire [NSRC-1:0] src_lines,     // Raw candidate sources
  input  wire [3:0]      source_sel,    // Selected source index
  input  wire            polarity,      // 1 = high level counts
  output reg             event_level    // Qualified event level
);

  // ----------------------------------------
  // Three-stage synchroniser per source line
  // ----------------------------------------
  reg [NSRC-1:0] sync1;                 // First stage, read only by sync2
  reg [NSRC-1:0] sync2;                 // Second stage
  reg [NSRC-1:0] sync3;                 // Third stage
  reg [NSRC-1:0] stable;                // Accepted level per line

  genvar g;
  generate
    for (g = 0; g < NSRC; g = g + 1) begin : g_sync
      // Shift chain, accept a change once stages two and three agree
      always @(posedge clk) begin
        if (reset) begin
          sync1[g]  <= 1'b0;
          sync2[g]  <= 1'b0;
          sync3[g]  <= 1'b0;
          stable[g] <= 1'b0;
        end else begin
          sync1[g] <= src_lines[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
          if (sync2[g] == sync3[g]) begin
            stable[g] <= sync3[g];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Level qualification by polarity
  // ----------------------------------------
  always @* begin
    // Present level, not a transition, is the event
    event_level = stable[source_sel] ~^ polarity;
  end

endmodule // edge_channel

/* charge_time_unit.v */
`timescale 1ns/1ps
`include "ctu_defines.vh"

module charge_time_unit #(
  parameter NSRC = `CTU_NSRC
) (
  input  wire                      clk,
  input  wire                      reset,
  // Edge sources
  input  wire [NSRC-1:0]           first_edge_sources,    // Pins and unit triggers for channel one
  input  wire [NSRC-1:0]           second_edge_sources,   // Pins and unit triggers for channel two
  // Control bits
  input  wire                      unit_enable,           // Module enable
  input  wire                      idle_stop_sel,         // Stop while idle
  input  wire                      idle_mode,             // Device is idle
  input  wire                      time_generation_select,// Delay generation mode
  input  wire                      edge_pass_enable,      // Edges not blocked
  input  wire                      edge_order_enable,     // First before second
  input  wire                      source_discharge_ctrl, // Ground the output
  input  wire                      conversion_trigger_enable, // Auto A/D start
  input  wire [`CTU_RANGE_W-1:0]   current_range_sel_in,  // Range field value
  input  wire [`CTU_TRIM_W-1:0]    current_trim_in,       // Trim field value
  input  wire                      cfg_write,             // Load range, trim and edge config
  input  wire [3:0]                first_edge_source_sel_in,
  input  wire [3:0]                second_edge_source_sel_in,
  input  wire                      first_edge_polarity_in,
  input  wire                      second_edge_polarity_in,
  // Software flag access
  input  wire                      flag_write,            // Write both flags
  input  wire [1:0]                flag_wdata,            // Bit1 second, bit0 first
  input  wire                      irq_enable,            // Interrupt enable bit
  input  wire                      irq_flag_clear,        // Software clears irq flag
  // Status and outputs
  output wire [1:0]                edge_flags,            // Bit1 second, bit0 first
  output reg                       irq_flag,              // Sticky interrupt flag
  output wire                      irq_request,           // Flag gated by enable
  output reg                       source_enable,         // Current source charging
  output reg                       source_ground,         // Output grounded
  output reg                       adc_trigger,           // One-cycle conversion start
  output reg                       delay_mode,            // Time generation active
  output reg  [`CTU_RANGE_W-1:0]   current_range_sel,     // Applied range
  output reg  [`CTU_TRIM_W-1:0]    current_trim,          // Applied trim
  output reg  [3:0]                range_multiplier_log   // 0..3 = x1..x1000
);

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  reg [3:0] first_edge_source_sel;      // Channel one source
  reg [3:0] second_edge_source_sel;     // Channel two source
  reg       first_edge_polarity;        // Channel one polarity
  reg       second_edge_polarity;       // Channel two polarity
  reg       first_edge_flag;            // Channel one status
  reg       second_edge_flag;           // Channel two status
  wire      first_level;                // Qualified channel one level
  wire      second_level;               // Qualified channel two level
  wire      running;                    // Unit active this cycle
  wire      next_source_enable;         // Exactly one flag set
  wire      first_hit;                  // Channel one event accepted
  wire      second_hit;                 // Channel two event accepted
  reg       next_first_flag;            // Next channel one flag
  reg       next_second_flag;           // Next channel two flag
  reg       order_required;             // Held order enable
  reg       trigger_armed;              // Held trigger enable
  wire      next_charging;              // Source state after next edge
  wire      source_turn_off;            // Source drops at next edge

  // ----------------------------------------
  // Usage notes
  // ----------------------------------------
  // Pin levels reach the flags four to five cycles late:
  // three synchroniser stages, acceptance, then the flag.
  // An active level keeps setting its flag, so a software
  // clear is lost for as long as the level persists.
  // Clear both flags in one write; clearing them one at a
  // time turns the source back on for a cycle.
  // Discharge holds the source off whatever the flags say,
  // and cutting a charge that way raises the interrupt flag.
  // Order and trigger enables act one cycle after a change.
  // Range and trim apply one cycle after a configuration
  // write, the multiplier code one cycle after that.
  // Idle stop and the unit enable block hardware flag sets but leave
  // software flag writes and the source output following the flags.

  // Latch configuration on write, reset to documented defaults
  always @(posedge clk) begin
    if (reset) begin
      // Defaults after reset
      first_edge_source_sel  <= `CTU_SEL_RESET;
      second_edge_source_sel <= `CTU_SEL_RESET;
      first_edge_polarity    <= `CTU_POL_RESET;
      second_edge_polarity   <= `CTU_POL_RESET;
      current_range_sel      <= `CTU_RANGE_X1000;
      current_trim           <= `CTU_TRIM_NEUTRAL;
    end else if (cfg_write) begin
      // Take the new configuration
      first_edge_source_sel  <= first_edge_source_sel_in;
      second_edge_source_sel <= second_edge_source_sel_in;
      first_edge_polarity    <= first_edge_polarity_in;
      second_edge_polarity   <= second_edge_polarity_in;
      current_range_sel      <= current_range_sel_in;
      current_trim           <= current_trim_in;
    end
  end

  // ----------------------------------------
  // Sequencing and trigger enables
  // ----------------------------------------
  // Held here so both read as clear straight after reset
  always @(posedge clk) begin
    if (reset) begin
      // No edge order, no conversion start
      order_required <= `CTU_ORDER_RESET;
      trigger_armed  <= `CTU_TRIG_RESET;
    end else begin
      // Follow the control inputs one cycle late
      order_required <= edge_order_enable;
      trigger_armed  <= conversion_trigger_enable;
    end
  end

  // ----------------------------------------
  // Edge channels
  // ----------------------------------------
  edge_channel #(
    .NSRC (NSRC)
  ) u_first (
    .clk         (clk),
    .reset       (reset),
    .src_lines   (first_edge_sources),
    .source_sel  (first_edge_source_sel),
    .polarity    (first_edge_polarity),
    .event_level (first_level)
  );

  edge_channel #(
    .NSRC (NSRC)
  ) u_second (
    .clk         (clk),
    .reset       (reset),
    .src_lines   (second_edge_sources),
    .source_sel  (second_edge_source_sel),
    .polarity    (second_edge_polarity),
    .event_level (second_level)
  );

  // ----------------------------------------
  // Event qualification
  // ----------------------------------------
  // Unit halts when disabled or idle with stop selected
  assign running    = unit_enable & ~(idle_stop_sel & idle_mode);
  // Levels only pass while edges are unblocked
  assign first_hit  = running & edge_pass_enable & first_level;
  // Second waits for first when ordering is on
  assign second_hit = running & edge_pass_enable & second_level &
                      (~order_required | first_edge_flag);

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  // Software write is applied, then hardware sets win
  always @* begin
    // Hold by default
    next_first_flag  = first_edge_flag;
    next_second_flag = second_edge_flag;
    // Software value applies first
    if (flag_write) begin
      next_first_flag  = flag_wdata[0];
      next_second_flag = flag_wdata[1];
    end
    // Hardware event overrides a software clear
    if (first_hit) begin
      next_first_flag = 1'b1;
    end
    // Same for the second channel
    if (second_hit) begin
      next_second_flag = 1'b1;
    end
  end

  // Flag registers
  always @(posedge clk) begin
    if (reset) begin
      // Both flags clear after reset
      first_edge_flag  <= 1'b0;
      second_edge_flag <= 1'b0;
    end else begin
      // Take the combined next state
      first_edge_flag  <= next_first_flag;
      second_edge_flag <= next_second_flag;
    end
  end

  assign edge_flags = {second_edge_flag, first_edge_flag};

  // ----------------------------------------
  // Current source gating
  // ----------------------------------------
  // Exactly one flag set means charging
  assign next_source_enable = first_edge_flag ^ second_edge_flag;
  // Discharge overrides the flags
  assign next_charging      = next_source_enable & ~source_discharge_ctrl;
  // Source on now and off after the coming edge
  assign source_turn_off    = source_enable & ~next_charging;

  // Source enable and ground outputs
  always @(posedge clk) begin
    if (reset) begin
      // Source idle and not grounded after reset
      source_enable <= 1'b0;
      source_ground <= 1'b0;
    end else begin
      // Charge only in the gap between edges
      source_enable <= next_charging;
      // Ground follows the discharge control
      source_ground <= source_discharge_ctrl;
    end
  end

  // ----------------------------------------
  // Mode, interrupt and conversion trigger
  // ----------------------------------------
  // Time generation mode flag
  always @(posedge clk) begin
    if (reset) begin
      // Measurement mode by default
      delay_mode <= `CTU_TIME_GENERATION_SELECT_RESET;
    end else begin
      // Delay generation when selected
      delay_mode <= time_generation_select;
    end
  end

  // Sticky interrupt flag, set wins over a clear
  always @(posedge clk) begin
    if (reset) begin
      irq_flag <= 1'b0;
    end else if (source_turn_off) begin
      // Source went on, now goes off
      irq_flag <= 1'b1;
    end else if (irq_flag_clear) begin
      // Software acknowledges
      irq_flag <= 1'b0;
    end
  end

  // Request needs both flag and enable
  assign irq_request = irq_flag & irq_enable;

  // One-cycle conversion start
  always @(posedge clk) begin
    if (reset) begin
      // No start pending after reset
      adc_trigger <= 1'b0;
    end else begin
      // Fire only when hardware newly sets the second flag
      adc_trigger <= trigger_armed & second_hit & ~second_edge_flag;
    end
  end

  // ----------------------------------------
  // Range decode
  // ----------------------------------------
  // Power-of-ten multiplier for the analog source
  always @(posedge clk) begin
    if (reset) begin
      // Reset range code 00 is the top range
      range_multiplier_log <= 4'h3;
    end else begin
      // Log ten of the multiplier for each range code
      case (current_range_sel)
        `CTU_RANGE_X1:   range_multiplier_log <= 4'h0;
        `CTU_RANGE_X10:  range_multiplier_log <= 4'h1;
        `CTU_RANGE_X100: range_multiplier_log <= 4'h2;
        default:         range_multiplier_log <= 4'h3;
      endcase
    end
  end

endmodule // charge_time_unit

/* ctu_assertions.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Port checker for the edge control unit
// ----------------------------------------
module ctu_assertions (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       flag_write,
  input wire logic [1:0] flag_wdata,
  input wire logic       edge_pass_enable,
  input wire logic       edge_order_enable,
  input wire logic       source_discharge_ctrl,
  input wire logic       irq_enable,
  input wire logic [1:0] current_range_sel,
  input wire logic [1:0] edge_flags,
  input wire logic       irq_flag,
  input wire logic       irq_request,
  input wire logic       source_enable,
  input wire logic       source_ground,
  input wire logic [3:0] range_multiplier_log
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_src; !$past(reset) |-> source_enable == (^$past(edge_flags) && !$past(source_discharge_ctrl)); endproperty
  a_src: assert property (p_src) else $error("source enable wrong");
  property p_gnd; !$past(reset) |-> source_ground == $past(source_discharge_ctrl); endproperty
  a_gnd: assert property (p_gnd) else $error("ground wrong");
  property p_irq; $fell(source_enable) |-> irq_flag; endproperty
  a_irq: assert property (p_irq) else $error("irq flag missing");
  property p_req; irq_request == (irq_flag && irq_enable); endproperty
  a_req: assert property (p_req) else $error("irq request wrong");
  property p_wr; flag_write |=> (edge_flags & $past(flag_wdata)) == $past(flag_wdata); endproperty
  a_wr: assert property (p_wr) else $error("flag write lost");
  property p_blk; (!edge_pass_enable && !flag_write) [*6] |=> (edge_flags & ~$past(edge_flags)) == 2'h0; endproperty
  a_blk: assert property (p_blk) else $error("edge passed while blocked");
  property p_ord; $past(edge_order_enable) && !$past(reset) && !flag_write && edge_flags == 2'h0 |=>
    edge_flags != 2'h2; endproperty
  a_ord: assert property (p_ord) else $error("second before first");
  property p_rng; $stable(current_range_sel) |-> range_multiplier_log == {2'h0, current_range_sel - 2'h1}; endproperty
  a_rng: assert property (p_rng) else $error("range decode wrong");
endmodule // ctu_assertions

bind charge_time_unit ctu_assertions u_chk (.clk(clk), .reset(reset), .flag_write(flag_write),
  .flag_wdata(flag_wdata), .edge_pass_enable(edge_pass_enable), .edge_order_enable(edge_order_enable),
  .source_discharge_ctrl(source_discharge_ctrl), .irq_enable(irq_enable), .current_range_sel(current_range_sel),
  .edge_flags(edge_flags), .irq_flag(irq_flag), .irq_request(irq_request), .source_enable(source_enable),
  .source_ground(source_ground), .range_multiplier_log(range_multiplier_log));

/* edge_src_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Edge pins and converter start counter
// ----------------------------------------
module edge_src_model #(parameter int A_IDX = 3, parameter int B_IDX = 5) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        pin_a,
  input  wire logic        pin_b,
  input  wire logic        adc_trigger,
  output logic      [15:0] src,
  output int               adc_n
);
  // Pins are held levels, capture triggers idle low
  assign src = ({15'h0, pin_a} << A_IDX) | ({15'h0, pin_b} << B_IDX);
  // Converter counts start pulses
  always @(posedge clk) adc_n <= reset ? 0 : adc_n + int'(adc_trigger);
endmodule // edge_src_model

/* testbench.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Self-checking bench
// ----------------------------------------
module testbench;
  logic        clk = 0, reset = 1, en = 0, isel = 0, idle = 0, tg = 0, pass = 0, ord = 0, dis = 0, trg = 0;
  logic        cw = 0, fwr = 0, ien = 0, icl = 0, pa = 0, pb = 0, p1 = 0, p2 = 0;
  logic [1:0]  rng = 0, fw = 0, flags, rsel;
  logic [5:0]  trim = 0, tr;
  logic [3:0]  s1 = 0, s2 = 0, rlog;
  logic [15:0] src;
  logic        irqf, irqr, sen, sgnd, adct, dm;
  int          err_total = 0, n_tests = 0, adc_n, cycles = 0;
  charge_time_unit DUT (.clk(clk), .reset(reset), .first_edge_sources(src), .second_edge_sources(src),
    .unit_enable(en), .idle_stop_sel(isel), .idle_mode(idle), .time_generation_select(tg),
    .edge_pass_enable(pass), .edge_order_enable(ord), .source_discharge_ctrl(dis),
    .conversion_trigger_enable(trg), .current_range_sel_in(rng), .current_trim_in(trim), .cfg_write(cw),
    .first_edge_source_sel_in(s1), .second_edge_source_sel_in(s2), .first_edge_polarity_in(p1),
    .second_edge_polarity_in(p2), .flag_write(fwr), .flag_wdata(fw), .irq_enable(ien), .irq_flag_clear(icl),
    .edge_flags(flags), .irq_flag(irqf), .irq_request(irqr), .source_enable(sen), .source_ground(sgnd),
    .adc_trigger(adct), .delay_mode(dm), .current_range_sel(rsel), .current_trim(tr), .range_multiplier_log(rlog));
  edge_src_model u_src (.clk(clk), .reset(reset), .pin_a(pa), .pin_b(pb), .adc_trigger(adct), .src(src),
    .adc_n(adc_n));
  // Clock and hang guard
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      give_verdict;
    end
  end
  task automatic give_verdict;
    if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Inputs change 1 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_flags(input logic [1:0] v);
    fw = v;
    fwr = 1;
    cyc(1);
    fwr = 0;
  endtask
  task automatic cfg(input logic [1:0] r, input logic [5:0] t, input logic a, input logic b);
    {rng, trim, s1, s2, p1, p2} = {r, t, 4'h3, 4'h5, a, b};
    cw = 1;
    cyc(1);
    cw = 0;
  endtask
  task automatic t_sw;
    en = 1;
    wr_flags(2'h1);
    cyc(2);
    check("one flag", {flags, sen}, 8'h03);
    wr_flags(2'h3);
    cyc(3);
    check("both flags", {flags, sen, irqf, irqr}, 8'h1a);
    ien = 1;
    cyc(1);
    check("irq request", irqr, 8'h01);
    icl = 1;
    cyc(1);
    icl = 0;
    wr_flags(2'h0);
    cyc(2);
    check("cleared", {flags, sen, irqf}, 8'h00);
  endtask
  task automatic t_cfg;
    tg = 1;
    for (int r = 0; r < 4; r++) begin
      cfg(r[1:0], 6'h21 + r[5:0], 1, 1);
      cyc(2);
      check("range", {rsel, 2'h0, rlog}, {r[1:0], 4'h0, 2'(r + 3)});
      check("trim", {rsel, tr}, {r[1:0], 6'h21 + r[5:0]});
    end
    check("delay mode", dm, 8'h01);
    tg = 0;
  endtask
  task automatic t_edges;
    en = 0;
    wr_flags(2'h0);
    {pass, ord, trg, pb} = 4'hf;
    cyc(1);
    en = 1;
    cyc(8);
    check("order", flags, 8'h00);
    pa = 1;
    cyc(8);
    check("sequence", {flags, 6'(adc_n)}, 8'hc1);
    ord = 0;
    wr_flags(2'h0);
    cyc(8);
    check("level", flags, 8'h03);
    {pass, pa, pb} = 3'h0;
    cyc(8);
    wr_flags(2'h0);
    {isel, idle, pass, pa} = 4'hf;
    cyc(8);
    check("idle", flags, 8'h00);
    idle = 0;
    cyc(8);
    check("wake", flags, 8'h01);
    {pass, pa} = 2'h0;
    cyc(8);
    wr_flags(2'h0);
    pass = 1;
    cfg(2'h1, 6'h0, 0, 0);
    cyc(8);
    check("match", flags, 8'h03);
    pass = 0;
    cyc(8);
    wr_flags(2'h0);
  endtask
  task automatic t_dis;
    wr_flags(2'h1);
    dis = 1;
    cyc(3);
    check("discharge", {sen, sgnd}, 8'h01);
    dis = 0;
    cyc(3);
    check("charge", {sen, sgnd}, 8'h02);
    wr_flags(2'h3);
    cyc(3);
    wr_flags(2'h0);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1 reset = 0;
    cyc(1);
    check("reset", {rsel, rlog}, 8'h03);
    check("reset out", {flags, irqf, sen, sgnd, adct, dm}, 8'h00);
    t_sw;
    t_cfg;
    t_edges;
    t_dis;
    give_verdict;
  end
endmodule // testbench
